// [rxpc_regs.sv]
module rxpc_regs
  import rxpc_pkg::*;
(
  // clock and reset
  input  wire logic       CLOCK,
  input  wire logic       RESET,
  // register access from the I2C target
  input  wire logic       REG_WR,
  input  wire logic       REG_WR_LOCAL,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  // power-down pin and rate straps
  input  wire logic       POWER_DOWN_PIN,
  input  wire logic [2:0] RATE_STRAP,
  // per-port datapath status
  input  wire logic [15:0] BIST_ERR_COUNT_IN,
  input  wire logic [1:0]  FWD_LOAD_VALID,
  input  wire logic [3:0]  FWD_PIN_COUNT_IN,
  input  wire logic [1:0]  ADDR_MATCH,
  // per-port controls
  output logic [1:0]      FORWARD_TXN,
  output logic [1:0]      ACK_ALL_WRITES,
  output logic [1:0]      RETURN_LINK_ENABLE,
  output logic [1:0]      RETURN_LINK_CHECK_GEN_ENABLE,
  output logic [5:0]      RETURN_LINK_RATE_SELECT,
  output logic [1:0]      KEEP_LOCAL_PATH_SETTINGS,
  output logic [3:0]      FORWARD_PIN_COUNT
);
  logic [7:0] psel_q;
  logic [1:0] pdn_meta_q, pdn_sync_q, pdn_prev_q;
  logic [2:0] strap_meta_q, strap_sync_q;
  logic [7:0] link_q [RXPC_PORTS];
  logic [7:0] path1_q [RXPC_PORTS];
  logic [7:0] path2_q [RXPC_PORTS];
  logic [7:0] bist_q [RXPC_PORTS];
  logic       strap_load;
  logic [7:0] rdata_d;

  // rate straps pass two flops, power-down pin passes four
  always_ff @(posedge CLOCK) begin
    pdn_meta_q   <= {pdn_meta_q[0], POWER_DOWN_PIN};
    strap_meta_q <= RATE_STRAP;
    strap_sync_q <= strap_meta_q;
    if (RESET) begin
      // idle level of the pin is high, so no false edge after reset
      pdn_sync_q <= 2'h3;
      pdn_prev_q <= 2'h3;
    end else begin
      pdn_sync_q <= {pdn_sync_q[0], pdn_meta_q[1]};
      pdn_prev_q <= pdn_sync_q;
    end
  end
  // rising power-down pin reloads the strapped rate
  assign strap_load = pdn_sync_q[1] & ~pdn_prev_q[1];

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      psel_q <= 8'h00;
    end else if (REG_WR && REG_ADDR == RXPC_ADDR_PSEL) begin
      psel_q <= REG_WDATA;
    end
  end

  genvar p;
  generate
    for (p = 0; p < RXPC_PORTS; p++) begin : g_port
      // low bits of port-select pick this port's copy
      logic wr_sel;
      assign wr_sel = REG_WR && psel_q[p];

      always_ff @(posedge CLOCK) begin
        bist_q[p] <= BIST_ERR_COUNT_IN[p*8 +: 8];
      end

      always_ff @(posedge CLOCK) begin
        if (RESET) begin
          link_q[p] <= {RXPC_LINK_RESET, strap_sync_q};
        end else if (strap_load) begin
          link_q[p][2:0] <= strap_sync_q;
        end else if (wr_sel && REG_ADDR == RXPC_ADDR_LINK) begin
          link_q[p][7:5] <= REG_WDATA[7:5];
          link_q[p][3]   <= REG_WDATA[3];
          if (REG_WR_LOCAL) begin
            link_q[p][4] <= REG_WDATA[4];
          end
          // reserved codes would glitch the link, so they are dropped
          if (REG_WDATA[2:0] == RXPC_RATE_2M5 || REG_WDATA[2:0] == RXPC_RATE_10M ||
              REG_WDATA[2:0] == RXPC_RATE_25M || REG_WDATA[2:0] == RXPC_RATE_50M) begin
            link_q[p][2:0] <= REG_WDATA[2:0];
          end
        end
      end

      always_ff @(posedge CLOCK) begin
        if (RESET) begin
          path1_q[p] <= RXPC_PATH_RESET;
          path2_q[p] <= RXPC_PATH_RESET;
        end else if (wr_sel && REG_ADDR == RXPC_ADDR_PATH1) begin
          path1_q[p][7:2] <= REG_WDATA[7:2];
          if (REG_WDATA[RXPC_KEEP_LOCAL] || path1_q[p][RXPC_KEEP_LOCAL]) begin
            path1_q[p][1:0] <= REG_WDATA[1:0];
          end
        end else if (wr_sel && REG_ADDR == RXPC_ADDR_PATH2) begin
          path2_q[p] <= REG_WDATA;
        end else if (FWD_LOAD_VALID[p] && !path1_q[p][RXPC_KEEP_LOCAL]) begin
          path1_q[p][1:0] <= FWD_PIN_COUNT_IN[p*2 +: 2];
        end
      end

      always_ff @(posedge CLOCK) begin
        if (RESET) begin
          FORWARD_TXN[p]                  <= 1'b0;
          ACK_ALL_WRITES[p]               <= 1'b0;
          RETURN_LINK_ENABLE[p]           <= 1'b0;
          RETURN_LINK_CHECK_GEN_ENABLE[p] <= 1'b0;
          RETURN_LINK_RATE_SELECT[p*3 +: 3] <= 3'h0;
          KEEP_LOCAL_PATH_SETTINGS[p]     <= 1'b0;
          FORWARD_PIN_COUNT[p*2 +: 2]     <= 2'h0;
        end else begin
          FORWARD_TXN[p] <= link_q[p][RXPC_FWD_ALL] |
                            (link_q[p][RXPC_FWD_MATCH] & ADDR_MATCH[p]);
          ACK_ALL_WRITES[p] <= link_q[p][RXPC_ACK_ALL];
          RETURN_LINK_ENABLE[p] <= link_q[p][RXPC_FORCED_ON] |
                                   link_q[p][RXPC_FWD_ALL] | link_q[p][RXPC_FWD_MATCH];
          RETURN_LINK_CHECK_GEN_ENABLE[p] <= link_q[p][RXPC_CHK_GEN];
          RETURN_LINK_RATE_SELECT[p*3 +: 3] <= link_q[p][2:0];
          KEEP_LOCAL_PATH_SETTINGS[p] <= path1_q[p][RXPC_KEEP_LOCAL];
          FORWARD_PIN_COUNT[p*2 +: 2] <= path1_q[p][1:0];
        end
      end
    end
  endgenerate

  // read returns the lowest selected port's copy
  always_comb begin
    rdata_d = 8'h00;
    if (REG_ADDR == RXPC_ADDR_PSEL) begin
      rdata_d = psel_q;
    end else begin
      for (int i = RXPC_PORTS - 1; i >= 0; i--) begin
        if (psel_q[i]) begin
          unique case (REG_ADDR)
            RXPC_ADDR_BIST:  rdata_d = bist_q[i];
            RXPC_ADDR_LINK:  rdata_d = link_q[i];
            RXPC_ADDR_PATH1: rdata_d = path1_q[i];
            RXPC_ADDR_PATH2: rdata_d = path2_q[i];
            default:         rdata_d = 8'h00;
          endcase
        end
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= rdata_d;
    end
  end
endmodule : rxpc_regs

// [rxpc_pkg.sv]
// Operation
// - separate copy per port, selected by port-select
// - self-test error count, 8-bit read-only
// - forward-all bit passes every transaction
// - forward-on-match bit passes matched transactions
// - acknowledge-every-write bit acks writes locally
// - forced-on bit keeps back channel enabled
// - else back channel needs a forwarding bit
// - forced-on writable only from local controller
// - check generation enable, resets to one
// - three-bit rate select, four defined codes
// - rate reset value from straps at power-up
// - override bit blocks forward-channel loading
// - forward pin count field, resets zero
// - host writes pin count only under override
package rxpc_pkg;
  localparam int          RXPC_PORTS       = 2;
  localparam logic [7:0]  RXPC_ADDR_PSEL   = 8'h4C;
  localparam logic [7:0]  RXPC_ADDR_BIST   = 8'h57;
  localparam logic [7:0]  RXPC_ADDR_LINK   = 8'h58;
  localparam logic [7:0]  RXPC_ADDR_PATH1  = 8'h59;
  localparam logic [7:0]  RXPC_ADDR_PATH2  = 8'h5A;
  localparam int          RXPC_FWD_ALL     = 7;
  localparam int          RXPC_FWD_MATCH   = 6;
  localparam int          RXPC_ACK_ALL     = 5;
  localparam int          RXPC_FORCED_ON   = 4;
  localparam int          RXPC_CHK_GEN     = 3;
  localparam int          RXPC_KEEP_LOCAL  = 7;
  localparam logic [4:0]  RXPC_LINK_RESET  = 5'h03;
  localparam logic [7:0]  RXPC_PATH_RESET  = 8'h00;
  localparam logic [2:0]  RXPC_RATE_2M5    = 3'h0;
  localparam logic [2:0]  RXPC_RATE_10M    = 3'h2;
  localparam logic [2:0]  RXPC_RATE_25M    = 3'h5;
  localparam logic [2:0]  RXPC_RATE_50M    = 3'h6;
endpackage : rxpc_pkg

// [rxpc_regs_asserts.sv]
module rxpc_regs_asserts import rxpc_pkg::*; (
  // clock and bus
  input wire logic       CLOCK,
  input wire logic       RESET,
  input wire logic       REG_WR,
  input wire logic [1:0] FWD_LOAD_VALID,
  // controls
  input wire logic [1:0] FORWARD_TXN,
  input wire logic [1:0] ACK_ALL_WRITES,
  input wire logic [1:0] RETURN_LINK_ENABLE,
  input wire logic [1:0] RETURN_LINK_CHECK_GEN_ENABLE,
  input wire logic [5:0] RETURN_LINK_RATE_SELECT,
  input wire logic [1:0] KEEP_LOCAL_PATH_SETTINGS,
  input wire logic [3:0] FORWARD_PIN_COUNT
);
  timeunit 1ns;
  timeprecision 1ns;
  // histories cover the two-to-three cycle write latency
  logic [3:0] wr_q, rst_q, ld_q;
  always_ff @(posedge CLOCK) begin
    wr_q  <= {wr_q[2:0], REG_WR};
    rst_q <= {rst_q[2:0], RESET};
    ld_q  <= {ld_q[2:0], |FWD_LOAD_VALID};
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  txn_needs_link_a: assert property ((FORWARD_TXN & ~RETURN_LINK_ENABLE) == 2'h0)
    else $error("forwarding without return link");
  rate_legal_a: assert property (!(RETURN_LINK_RATE_SELECT[2:0] inside {3'h1, 3'h3, 3'h7}))
    else $error("reserved rate on port 0");
  rate_legal_one_a: assert property (!(RETURN_LINK_RATE_SELECT[5:3] inside {3'h1, 3'h3, 3'h7}))
    else $error("reserved rate on port 1");
  check_gen_a: assert property ($changed(RETURN_LINK_CHECK_GEN_ENABLE) |-> |{wr_q, rst_q})
    else $error("check enable moved without cause");
  ack_all_a: assert property ($changed(ACK_ALL_WRITES) |-> |wr_q)
    else $error("ack enable moved without write");
  keep_local_a: assert property ($changed(KEEP_LOCAL_PATH_SETTINGS) |-> |wr_q)
    else $error("override moved without write");
  pin_count_a: assert property ($changed(FORWARD_PIN_COUNT) |-> |{wr_q, ld_q})
    else $error("pin count moved without cause");
  link_enable_a: assert property ($changed(RETURN_LINK_ENABLE) |-> |{wr_q, rst_q})
    else $error("return link moved without cause");
endmodule : rxpc_regs_asserts

// [rxpc_remote_model.sv]
module rxpc_remote_model (
  // strobe from bench
  input wire logic       clock,
  input wire logic [1:0] send,
  input wire logic [3:0] count,
  // forward channel load
  output logic     [1:0] load_valid,
  output logic     [3:0] pin_count
);
  timeunit 1ns;
  timeprecision 1ns;
  initial load_valid = 2'h0;
  initial pin_count = 4'h0;
  // count only valid with its strobe, inverse shown otherwise
  always @(posedge clock) begin
    load_valid <= #1 send;
    pin_count  <= #1 (|send) ? count : ~count;
  end
endmodule : rxpc_remote_model

// [tb_rxpc_regs.sv]
module tb_rxpc_regs import rxpc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLOCK = 0, RESET = 1, REG_WR = 0, REG_WR_LOCAL = 0, POWER_DOWN_PIN = 1;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA;
  logic [2:0] RATE_STRAP = 3'h6, bad[4] = '{3'h1, 3'h3, 3'h4, 3'h7};
  logic [15:0] BIST_ERR_COUNT_IN = 16'h0000;
  logic [1:0] ADDR_MATCH = 0, send = 0, kind = 0, kind_d = 0, pin, FWD_LOAD_VALID, FORWARD_TXN, ACK_ALL_WRITES;
  logic [1:0] RETURN_LINK_ENABLE, RETURN_LINK_CHECK_GEN_ENABLE, KEEP_LOCAL_PATH_SETTINGS;
  logic [5:0] RETURN_LINK_RATE_SELECT;
  logic [3:0] FWD_PIN_COUNT_IN, FORWARD_PIN_COUNT, cnt = 0;
  logic [9:0] note_q[$], exp_v, got_v;
  int error_cnt = 0, total_checks = 0;
  rxpc_regs rxpc_regs_inst (.*);
  rxpc_remote_model rxpc_remote_model_inst (.clock(CLOCK), .send(send), .count(cnt),
    .load_valid(FWD_LOAD_VALID), .pin_count(FWD_PIN_COUNT_IN));
  always #25 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    if (kind_d != 2'h0) begin
      total_checks++;
      exp_v = note_q.pop_front();
      got_v = (kind_d == 2'h3) ? {FORWARD_PIN_COUNT[3:2], FORWARD_TXN[1], KEEP_LOCAL_PATH_SETTINGS[1],
        ACK_ALL_WRITES[1], RETURN_LINK_ENABLE[1], RETURN_LINK_CHECK_GEN_ENABLE[1], RETURN_LINK_RATE_SELECT[5:3]} :
        kind_d[1] ? {FORWARD_PIN_COUNT[1:0], FORWARD_TXN[0], KEEP_LOCAL_PATH_SETTINGS[0], ACK_ALL_WRITES[0],
        RETURN_LINK_ENABLE[0], RETURN_LINK_CHECK_GEN_ENABLE[0], RETURN_LINK_RATE_SELECT[2:0]} : {2'h0, REG_RDATA};
      if (got_v !== exp_v) begin
        error_cnt++;
        $display("CHECK FAILED %s expected %h seen %h", kind_d[1] ? "outputs" : "read", exp_v, got_v);
      end
    end
    kind_d <= kind;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic loc);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR_LOCAL = loc;
    REG_WR = 1;
    @(posedge CLOCK) #1 REG_WR = 0;
    @(posedge CLOCK) #1;
  endtask : wr
  // kind 1 reads a register, kind 2 snapshots port 0 outputs, kind 3 port 1
  task automatic chk(input logic [1:0] k, input logic [7:0] a, input logic [9:0] e);
    REG_ADDR = a;
    kind = k;
    note_q.push_back(e);
    @(posedge CLOCK) #1 kind = 0;
    @(posedge CLOCK) #1;
  endtask : chk
  task automatic load(input logic [1:0] p, input logic [3:0] c);
    send = p;
    cnt = c;
    @(posedge CLOCK) #1 send = 0;
    repeat (3) @(posedge CLOCK);
    #1;
  endtask : load
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  initial begin
    #100000;
    error_cnt++;
    close_out();
  end
  initial begin
    void'($urandom(32'h9B08));
    BIST_ERR_COUNT_IN = 16'($urandom());
    pin = 2'($urandom());
    repeat (6) @(posedge CLOCK);
    #1 RESET = 0;
    wr(RXPC_ADDR_PSEL, 8'h01, 1);
    chk(1, RXPC_ADDR_LINK, {RXPC_LINK_RESET, RATE_STRAP});
    wr(RXPC_ADDR_BIST, 8'h00, 1);
    chk(1, RXPC_ADDR_BIST, BIST_ERR_COUNT_IN[7:0]);
    wr(RXPC_ADDR_LINK, 8'h02, 0);
    chk(1, RXPC_ADDR_LINK, 10'h012);
    wr(RXPC_ADDR_LINK, 8'h05, 1);
    chk(2, 0, 10'h005);
    for (int i = 0; i < 4; i++) begin
      wr(RXPC_ADDR_LINK, {5'h14, bad[i]}, 1);
      chk(1, RXPC_ADDR_LINK, 10'h0A5);
      chk(2, 0, 10'h0B5);
    end
    wr(RXPC_ADDR_LINK, 8'h40, 1);
    ADDR_MATCH = 2'h1;
    chk(2, 0, 10'h090);
    ADDR_MATCH = 2'h0;
    wr(RXPC_ADDR_PSEL, 8'h02, 1);
    chk(1, RXPC_ADDR_LINK, {RXPC_LINK_RESET, RATE_STRAP});
    wr(RXPC_ADDR_PATH1, 8'h83, 1);
    load(2'h2, 4'h4);
    chk(1, RXPC_ADDR_PATH1, 10'h083);
    chk(3, 0, 10'h35E);
    wr(RXPC_ADDR_PSEL, 8'h01, 1);
    load(2'h1, {2'h0, pin});
    chk(1, RXPC_ADDR_PATH1, {8'h00, pin});
    wr(RXPC_ADDR_PATH1, {6'h00, ~pin}, 1);
    chk(2, 0, {pin, 8'h10});
    repeat (3) @(posedge CLOCK);
    close_out();
  end
endmodule : tb_rxpc_regs
bind rxpc_regs rxpc_regs_asserts rxpc_regs_asserts_inst (.*);
